/* File: logic/i2cc_ctrl.sv */
// Purpose: Two-wire bus control and status with AHB-Lite register access.
// Assumes: Open-drain pins, oe high pulls the line low; one AHB slave.
// Notes:   Master engine runs on divider ticks, slave engine on bus edges.
// Functional notes
// - Lost arbitration clears master and transmit select, slave receive.
// - Own-address slave picks transmit or receive from first byte R/W bit; general call always receives.
// - Select bits decode slave rx, slave tx, master rx, master tx.
// - Acknowledge mode adds one ack bit per frame; serial mode does not.
// - Standard range divides clock by 28 to 128.
// - Extended range divides clock by 56 to 256.
// - Status register resets to 30 hex.
// - Start sets bus busy, stop clears it, in every mode.
// - Busy write with prohibit zero issues start or stop in master mode.
// - Busy writes ignored in slave mode.
// - Master sets request flag at transfer end and arbitration loss.
// - Addressed slave flags match then each transfer until start or stop.
// - Non-addressing slave flags every transfer end.
// - Request flag clears only on zero write after reading it set.
// - Four flags accept only zero writes, which clear them.
// - Prohibit bit reads one and is not stored.
// - Status bit 4 reads one, ignores writes.
// - Flag timing follows acknowledge mode, and wait insertion in master mode only.
// - In master mode, wait holds SCL low before ack until request flag clears.
// - Bit count code 000 means 8; counter clears on start and frame end.
// - Interface disabled releases both pins and stops transfers.
// - Arbitration loss also sets the request flag.
`timescale 1ns/1ps
module i2cc_ctrl
    import i2cc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             irq
);
    typedef struct packed {
        logic [7:0]   ctl;
        logic         mls;
        logic         wait_en;
        logic [2:0]   bc;
        logic [7:0]   slave_addr_reg;
        logic         xclk;
        logic [7:0]   shift;
        logic         bb;
        logic         irqf;
        logic         al;
        logic         own_address_seen_flag;
        logic         general_call_seen_flag;
        logic         ack_sw;
        logic         ack_rx;
        logic [3:0]   arm;
        i2cc_mstate_t st;
        logic         stp;
        logic [3:0]   cnt;
        logic         first;
        logic         addressed;
        logic         req_start;
        logic         req_stop;
        logic         go;
        logic         scl_oe;
        logic         sda_oe;
        logic         scl_m1;
        logic         scl_m2;
        logic         scl_p;
        logic         sda_m1;
        logic         sda_m2;
        logic         sda_p;
        logic         a_ph;
        logic         a_wr;
        logic [2:0]   a_idx;
        logic [31:0]  hrdata;
        logic         rdy;
        logic         irq;
    } i2cc_state_t;

    localparam i2cc_state_t ST_RST = '{st: M_IDLE, rdy: 1'b1, scl_m1: 1'b1, scl_m2: 1'b1,
                                       scl_p: 1'b1, sda_m1: 1'b1, sda_m2: 1'b1,
                                       sda_p: 1'b1, default: '0};

    i2cc_state_t q;
    i2cc_state_t d;

    i2cc_clk_if cif ();

    logic       ifen;
    logic       master_select;
    logic       transmit_select;
    logic       ackm;
    logic [3:0] nbits;
    logic [3:0] total;
    logic       start_det;
    logic       stop_det;
    logic       scl_rise;
    logic       scl_fall;
    logic [7:0] rd_byte;
    logic [7:0] div_sel;
    logic [2:0] cks;

    assign ifen  = q.ctl[B_IFEN];
    assign master_select   = q.ctl[B_MST];
    assign transmit_select   = q.ctl[B_TRS];
    assign ackm  = ~q.ctl[B_ACKM];
    assign cks   = q.ctl[B_CKS +: 3];
    assign nbits = (q.bc == 3'h0) ? FULL_FRAME : {1'b0, q.bc};
    assign total = nbits + {3'h0, ackm};

    // Bus condition and edge detection on synchronised lines
    assign start_det = q.scl_m2 & q.scl_p & q.sda_p & ~q.sda_m2;
    assign stop_det  = q.scl_m2 & q.scl_p & ~q.sda_p & q.sda_m2;
    assign scl_rise  = q.scl_m2 & ~q.scl_p;
    assign scl_fall  = ~q.scl_m2 & q.scl_p;

    // Divide ratio selection, halved for the phase counter
    always_comb begin
        div_sel = q.xclk ? DIV_EXT[cks][8:1] : DIV_STD[cks][8:1];
    end

    assign cif.run  = master_select & ifen & (q.st != M_IDLE);
    assign cif.half = div_sel;

    i2cc_sclgen #(
        .CNT_W (8)
    ) u_sclgen (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cif     (cif)
    );

    function automatic logic out_bit(input logic [7:0] s, input logic lsb);
        return lsb ? s[0] : s[7];
    endfunction

    function automatic logic [7:0] shl(input logic [7:0] s, input logic b, input logic lsb);
        return lsb ? {b, s[7:1]} : {s[6:0], b};
    endfunction

    // Pull-down for master bit c: data when sending, ack when receiving
    function automatic logic mdrive(input logic [3:0] c, input logic [3:0] nb,
                                    input logic [7:0] s, input logic tx,
                                    input logic lsb, input logic ackv);
        if (c < nb) begin
            return tx & ~out_bit(s, lsb);
        end
        return ~tx & ~ackv;
    endfunction

    // Register read view
    always_comb begin
        case (haddr[4:2])
            IDX_CTRL:   rd_byte = q.ctl;
            IDX_STATUS: rd_byte = STATUS_ONES | {q.bb, q.irqf, 2'b00, q.al, q.own_address_seen_flag, q.general_call_seen_flag,
                                                 transmit_select ? q.ack_rx : q.ack_sw};
            IDX_MODE:   rd_byte = MODE_ONES | {q.mls, q.wait_en, 3'b000, q.bc};
            IDX_SADDR:  rd_byte = q.slave_addr_reg;
            IDX_TIMER:  rd_byte = {2'b00, q.xclk, 5'b00000};
            IDX_DATA:   rd_byte = q.shift;
            default:    rd_byte = ZERO_BYTE;
        endcase
    end

    always_comb begin
        logic [3:0] c1;
        logic [7:0] s2;
        logic       lost;
        c1   = q.cnt + 4'h1;
        s2   = shl(q.shift, q.sda_m2, q.mls);
        lost = 1'b0;
        d    = q;
        d.go = 1'b0;

        // Pin synchronisers
        d.scl_m1 = scl_i;
        d.scl_m2 = q.scl_m1;
        d.scl_p  = q.scl_m2;
        d.sda_m1 = sda_i;
        d.sda_m2 = q.sda_m1;
        d.sda_p  = q.sda_m2;

        // AHB address phase, zero wait states
        d.a_ph = hsel & htrans[1] & hready;
        if (d.a_ph) begin
            d.a_wr  = hwrite;
            d.a_idx = haddr[4:2];
            if (!hwrite) begin
                d.hrdata = {24'h000000, rd_byte};
                if (haddr[4:2] == IDX_STATUS) begin
                    d.arm = {q.irqf, q.al, q.own_address_seen_flag, q.general_call_seen_flag};
                end
                if (haddr[4:2] == IDX_DATA) begin
                    d.go  = 1'b1;
                    d.al  = 1'b0;
                    d.own_address_seen_flag = 1'b0;
                    d.general_call_seen_flag = 1'b0;
                end
            end
        end

        // AHB data phase writes
        if (q.a_ph && q.a_wr) begin
            case (q.a_idx)
                IDX_CTRL: begin
                    d.ctl = hwdata[7:0];
                end
                IDX_STATUS: begin
                    if (!hwdata[S_IRQ] && q.arm[3]) d.irqf = 1'b0;
                    if (!hwdata[S_AL] && q.arm[2]) d.al = 1'b0;
                    if (!hwdata[S_AAS] && q.arm[1]) d.own_address_seen_flag = 1'b0;
                    if (!hwdata[S_ADZ] && q.arm[0]) d.general_call_seen_flag = 1'b0;
                    d.arm = (d.a_ph && !hwrite && haddr[4:2] == IDX_STATUS) ? d.arm : 4'h0;
                    d.ack_sw = hwdata[S_ACKNOWLEDGE_VALUE];
                    if (!hwdata[S_SCP] && master_select && ifen) begin
                        d.req_start = hwdata[S_BB];
                        d.req_stop  = ~hwdata[S_BB];
                    end
                end
                IDX_MODE: begin
                    d.mls     = hwdata[M_MLS];
                    d.wait_en = hwdata[M_WINS];
                    d.bc      = hwdata[2:0];
                end
                IDX_SADDR: begin
                    d.slave_addr_reg = hwdata[7:0];
                end
                IDX_TIMER: begin
                    d.xclk = hwdata[T_XCLK];
                end
                IDX_DATA: begin
                    d.shift = hwdata[7:0];
                    d.go    = 1'b1;
                    d.al    = 1'b0;
                    d.own_address_seen_flag   = 1'b0;
                    d.general_call_seen_flag   = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // Bus busy tracking and frame counter restart
        if (start_det) begin
            d.bb        = 1'b1;
            d.cnt       = 4'h0;
            d.first     = 1'b1;
            d.addressed = q.slave_addr_reg[A_FS];
        end
        if (stop_det) begin
            d.bb        = 1'b0;
            d.addressed = 1'b0;
        end

        if (!ifen) begin
            d.st        = M_IDLE;
            d.scl_oe    = 1'b0;
            d.sda_oe    = 1'b0;
            d.req_start = 1'b0;
            d.req_stop  = 1'b0;
        end else if (master_select) begin
            case (q.st)
                M_IDLE: begin
                    d.req_stop = 1'b0;
                    if (q.req_start && !q.bb) d.st = M_STA;
                end
                M_REL: begin
                    d.sda_oe = 1'b0;
                    if (cif.tick) begin
                        d.scl_oe = 1'b0;
                        d.st     = M_STA;
                    end
                end
                M_STA: begin
                    if (cif.tick && q.scl_m2) begin
                        if (!q.sda_oe) begin
                            d.sda_oe = 1'b1;
                        end else begin
                            d.scl_oe    = 1'b1;
                            d.req_start = 1'b0;
                            d.cnt       = 4'h0;
                            d.st        = M_HOLD;
                        end
                    end
                end
                M_HOLD: begin
                    d.scl_oe = 1'b1;
                    if (q.stp) begin
                        // Stop: SDA low, SCL up, then SDA up
                        if (cif.tick && q.scl_oe) begin
                            d.scl_oe = 1'b0;
                        end else if (cif.tick && q.scl_m2) begin
                            d.scl_oe   = 1'b0;
                            d.sda_oe   = 1'b0;
                            d.req_stop = 1'b0;
                            d.stp      = 1'b0;
                            d.st       = M_IDLE;
                        end else begin
                            d.scl_oe = q.scl_oe;
                        end
                    end else if (q.req_start) begin
                        d.st = M_REL;
                    end else if (q.req_stop) begin
                        d.sda_oe = 1'b1;
                        d.stp    = 1'b1;
                    end else if (q.go) begin
                        d.cnt    = 4'h0;
                        d.sda_oe = mdrive(4'h0, nbits, q.shift, transmit_select, q.mls, q.ack_sw);
                        d.st     = M_LO;
                    end
                end
                M_LO: begin
                    if (cif.tick) begin
                        d.scl_oe = 1'b0;
                        d.st     = M_HI;
                    end
                end
                M_HI: begin
                    if (cif.tick && q.scl_m2) begin
                        if (q.cnt < nbits) begin
                            lost    = transmit_select & out_bit(q.shift, q.mls) & ~q.sda_m2;
                            d.shift = s2;
                        end else begin
                            d.ack_rx = q.sda_m2;
                        end
                        if (lost) begin
                            d.al       = 1'b1;
                            d.irqf     = 1'b1;
                            d.ctl[B_MST] = 1'b0;
                            d.ctl[B_TRS] = 1'b0;
                            d.scl_oe   = 1'b0;
                            d.sda_oe   = 1'b0;
                            d.st       = M_IDLE;
                        end else if (c1 >= total) begin
                            d.scl_oe = 1'b1;
                            d.sda_oe = 1'b0;
                            d.cnt    = 4'h0;
                            d.irqf   = 1'b1;
                            d.st     = M_HOLD;
                        end else begin
                            d.scl_oe = 1'b1;
                            d.cnt    = c1;
                            d.sda_oe = mdrive(c1, nbits, d.shift, transmit_select, q.mls, q.ack_sw);
                            if (c1 == nbits && ackm && q.wait_en) begin
                                d.irqf = 1'b1;
                                d.st   = M_WAIT;
                            end else begin
                                d.st = M_LO;
                            end
                        end
                    end
                end
                M_WAIT: begin
                    d.scl_oe = 1'b1;
                    if (!q.irqf) d.st = M_LO;
                end
                default: begin
                    d.st = M_IDLE;
                end
            endcase
        end else begin
            // Slave engine on bus clock edges
            d.st     = M_IDLE;
            d.scl_oe = 1'b0;
            if (stop_det) d.sda_oe = 1'b0;
            if (scl_rise && q.bb) begin
                if (q.cnt < nbits) begin
                    d.shift = s2;
                end else begin
                    d.ack_rx = q.sda_m2;
                end
                if (c1 == nbits && q.first && !q.slave_addr_reg[A_FS]) begin
                    if (s2[7:1] == q.slave_addr_reg[7:1]) begin
                        d.own_address_seen_flag        = 1'b1;
                        d.irqf       = 1'b1;
                        d.addressed  = 1'b1;
                        d.ctl[B_TRS] = s2[0];
                    end else if (s2[7:1] == GCALL_ADDR) begin
                        d.own_address_seen_flag        = 1'b1;
                        d.general_call_seen_flag        = 1'b1;
                        d.irqf       = 1'b1;
                        d.addressed  = 1'b1;
                        d.ctl[B_TRS] = 1'b0;
                    end
                end
                if (c1 >= total) begin
                    d.cnt   = 4'h0;
                    d.first = 1'b0;
                    if (q.addressed && (q.slave_addr_reg[A_FS] || !q.first)) begin
                        d.irqf = 1'b1;
                    end
                end else begin
                    d.cnt = c1;
                end
            end
            if (scl_fall && q.bb) begin
                if (q.cnt < nbits) begin
                    d.sda_oe = transmit_select & q.addressed & ~out_bit(q.shift, q.mls);
                end else if (q.first) begin
                    d.sda_oe = q.addressed & ~q.slave_addr_reg[A_FS];
                end else begin
                    d.sda_oe = ~transmit_select & q.addressed & ~q.ack_sw;
                end
            end
        end

        d.rdy = 1'b1;
        d.irq = d.irqf & d.ctl[B_IRQEN];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign hrdata    = q.hrdata;
    assign hreadyout = q.rdy;
    assign hresp     = 1'b0;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe    = q.scl_oe;
    assign sda_oe    = q.sda_oe;
    assign irq       = q.irq;
endmodule // i2cc_ctrl

/* File: pkg/i2cc_pkg.sv */
// Purpose: Shared constants and types for the two-wire bus control block.
// Assumes: AHB-Lite word registers, byte offset = 4 * register index.
// Notes:   Divide tables are indexed by the three clock-select bits.
package i2cc_pkg;

    // Register word indices (haddr[4:2])
    localparam logic [2:0] IDX_CTRL   = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_MODE   = 3'h2;
    localparam logic [2:0] IDX_SADDR  = 3'h3;
    localparam logic [2:0] IDX_TIMER  = 3'h4;
    localparam logic [2:0] IDX_DATA   = 3'h5;

    // bus_control fields
    localparam int B_IFEN  = 7;
    localparam int B_IRQEN = 6;
    localparam int B_MST   = 5;
    localparam int B_TRS   = 4;
    localparam int B_ACKM  = 3;
    localparam int B_CKS   = 0;

    // bus_status fields
    localparam int S_BB   = 7;
    localparam int S_IRQ  = 6;
    localparam int S_SCP  = 5;
    localparam int S_AL   = 3;
    localparam int S_AAS  = 2;
    localparam int S_ADZ  = 1;
    localparam int S_ACKNOWLEDGE_VALUE = 0;

    // bus_mode_reg, serial_timer_control, slave_addr_reg fields
    localparam int M_MLS  = 7;
    localparam int M_WINS = 6;
    localparam int T_XCLK = 5;
    localparam int A_FS   = 0;

    // Bits that always read as one, then fixed byte, frame and address values
    localparam logic [7:0] STATUS_ONES = 8'h30;
    localparam logic [7:0] MODE_ONES   = 8'h38;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    localparam logic [3:0] FULL_FRAME  = 4'h8;
    localparam logic [6:0] GCALL_ADDR  = 7'h00;

    // Serial clock divide ratios, standard and extended range
    localparam logic [8:0] DIV_STD [8] = '{9'h01C, 9'h028, 9'h030, 9'h040,
                                           9'h050, 9'h064, 9'h070, 9'h080};
    localparam logic [8:0] DIV_EXT [8] = '{9'h038, 9'h050, 9'h060, 9'h080,
                                           9'h0A0, 9'h0C8, 9'h0E0, 9'h100};

    typedef enum logic [6:0] {
        M_IDLE = 7'h01,
        M_REL  = 7'h02,
        M_STA  = 7'h04,
        M_LO   = 7'h08,
        M_HI   = 7'h10,
        M_WAIT = 7'h20,
        M_HOLD = 7'h40
    } i2cc_mstate_t;

    localparam i2cc_mstate_t M_STP = M_IDLE;

endpackage

/* File: pkg/i2cc_clk_if.sv */
// Purpose: Carrier between the control block and its serial clock divider.
// Assumes: Single clock domain.
// Notes:   half is half the selected divide ratio.
`timescale 1ns/1ps
interface i2cc_clk_if;
    logic       run;
    logic [7:0] half;
    logic       tick;
    modport ctl (output run, output half, input tick);
    modport gen (input run, input half, output tick);
endinterface

/* File: logic/i2cc_sclgen.sv */
// Purpose: Serial clock phase divider, one tick per half period.
// Assumes: half is at least 1 while run is high.
// Notes:   Counter restarts whenever run drops.
`timescale 1ns/1ps
module i2cc_sclgen
    import i2cc_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    i2cc_clk_if.gen   cif
);
    generate
        if (CNT_W < 8) begin : g_chk
            $error("i2cc_sclgen: CNT_W too small for divide table");
        end
    endgenerate

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } i2cc_gen_t;

    i2cc_gen_t q;
    i2cc_gen_t d;

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (!cif.run) begin
            d.cnt = '0;
        end else if (d.cnt >= CNT_W'(cif.half - 8'h01)) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cif.tick = q.tick;
endmodule // i2cc_sclgen

/* File: dv/i2cc_ctrl_asserts.sv */
// Purpose: Port checks for i2cc_ctrl.
// Assumes: Bound from the bench.
// Notes:   One clock domain.
`timescale 1ns/1ps
module i2cc_ctrl_asserts
    import i2cc_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        scl_o,
    input wire logic        scl_oe,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd = hsel && htrans[1] && hready && !hwrite;
    chk_status_ones: assert property (rd && haddr[4:2] == IDX_STATUS |=> hrdata[5:4] == 2'h3)
        else $error("status ones");
    chk_rdata_stands: assert property (!rd |=> $stable(hrdata))
        else $error("rdata moved");
    chk_open_drain: assert property (!scl_o && !sda_o)
        else $error("pin high");
    chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && !scl_oe && !sda_oe)
        else $error("not quiet");
    chk_start_clock: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:300] scl_oe)
        else $error("no clock");
    chk_stop_free: assert property ($fell(sda_oe) && !scl_oe |=> !scl_oe[*8])
        else $error("stop");
    chk_scl_low_min: assert property ($rose(scl_oe) |-> scl_oe[*8] ##1 scl_oe[*6])
        else $error("low short");
    chk_scl_high_min: assert property ($fell(scl_oe) |-> !scl_oe[*8] ##1 !scl_oe[*6])
        else $error("high short");
    chk_irq_held: assert property ($rose(irq) && scl_oe |=> scl_oe[*3])
        else $error("irq hold");
    cover property ($rose(sda_oe) && !scl_oe);
    cover property ($rose(irq));
    cover property (rd && haddr[4:2] == IDX_STATUS);
endmodule // i2cc_ctrl_asserts

/* File: dv/i2cc_peer.sv */
// Purpose: Slave on the wires, acks each frame.
// Assumes: Wires already resolved.
// Notes:   slow stretches SCL after each fall.
`timescale 1ns/1ps
module i2cc_peer (
    input wire logic hclk,
    input wire logic scl,
    input wire logic sda,
    input wire logic slow,
    output logic     scl_pull,
    output logic     sda_pull
);
    logic scl_q = 1'b1, sda_q = 1'b1;
    int   bits = 0, hold = 0;
    initial {scl_pull, sda_pull} = 2'h0;
    always @(posedge hclk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && sda_q && !sda)
            bits <= 0;
        if (scl_q && !scl) begin
            bits <= (bits == 9) ? 1 : bits + 1;
            sda_pull <= (bits == 8);
            scl_pull <= slow;
            hold <= 150; // Outlasts the longest master low phase
        end else if (hold > 0)
            hold <= hold - 1;
        else
            scl_pull <= 1'b0;
    end
endmodule // i2cc_peer

/* File: dv/i2cc_ctrl_bench.sv */
// Purpose: Self-checking bench for i2cc_ctrl.
// Assumes: One peer acks every frame.
// Notes:   Reads are checked through a note queue.
`timescale 1ns/1ps
module i2cc_ctrl_bench import i2cc_pkg::*;;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow, rph;
    logic        scl_o, scl_oe, sda_o, sda_oe, irq, pscl, psda;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [7:0]  v, exp_q[$];
    int          failures, comparisons, seed, n;
    wire         scl_w = !(scl_oe || pscl);
    wire         sda_w = !(sda_oe || psda);
    i2cc_ctrl i2cc_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w),
        .sda_o, .sda_oe, .irq);
    i2cc_peer i2cc_peer_i (.hclk, .scl(scl_w), .sda(sda_w), .slow, .scl_pull(pscl), .sda_pull(psda));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
        haddr <= {27'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdx(input logic [2:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 8'h00);
    endtask
    task automatic till(input logic sel, input logic lvl);
        n = 0;
        while ((sel ? irq : scl_oe) !== lvl && n < 4000) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic frame(input logic [7:0] d, input int r);
        int p;
        bus(1'b1, IDX_DATA, d);
        if (r > 0) begin
            till(1'b0, 1'b0);
            till(1'b0, 1'b1);
            till(1'b0, 1'b0);
            p = n;
            till(1'b0, 1'b1);
            chk(p + n >= r && p + n <= r + 4, 1'b1);
        end
        till(1'b1, 1'b1);
        chk(irq, 1'b1);
        bus(1'b1, IDX_STATUS, 8'h20);
        rdx(IDX_STATUS, 8'hF0);
        bus(1'b1, IDX_STATUS, 8'hA0);
        rdx(IDX_STATUS, 8'hB0);
    endtask
    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge hclk) begin
        if (rph && exp_q.size() > 0)
            chk(hrdata, {24'h0, exp_q.pop_front()});
        rph <= htrans[1] && !hwrite && hreadyout && exp_q.size() > 0;
    end
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        #(25 * 40000);
        failures++;
        final_report;
    end
    initial begin
        {hsel, htrans, haddr, hwdata, hwrite, slow, rph, hresetn} = {1'b1, 70'h0};
        {seed, failures, comparisons} = {32'd69638, 64'h0};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdx(IDX_STATUS, STATUS_ONES);
        rdx(IDX_CTRL, ZERO_BYTE);
        for (int i = 0; i < 4; i++) begin
            v = 8'h7F & $random(seed);
            bus(1'b1, IDX_CTRL, v);
            rdx(IDX_CTRL, v);
        end
        bus(1'b1, IDX_TIMER, 8'hFF);
        rdx(IDX_TIMER, 8'h20);
        bus(1'b1, IDX_CTRL, 8'h80);
        bus(1'b1, IDX_STATUS, 8'hDE);
        rdx(IDX_STATUS, STATUS_ONES);
        bus(1'b1, 3'h6, 8'hFF);
        rdx(3'h6, ZERO_BYTE);
        v = 8'hF0 | (8'h07 & $random(seed));
        bus(1'b1, IDX_CTRL, v);
        bus(1'b1, IDX_STATUS, 8'h80);
        till(1'b0, 1'b1);
        rdx(IDX_STATUS, 8'hB0);
        frame($random(seed), DIV_EXT[v[2:0]]);
        bus(1'b1, IDX_TIMER, ZERO_BYTE);
        bus(1'b1, IDX_MODE, 8'h40);
        rdx(IDX_MODE, 8'h78);
        frame($random(seed), DIV_STD[v[2:0]]);
        till(1'b1, 1'b1);
        rdx(IDX_STATUS, 8'hF0);
        bus(1'b1, IDX_STATUS, 8'hA0);
        bus(1'b1, IDX_MODE, ZERO_BYTE);
        slow <= 1'b1;
        frame($random(seed), 0);
        bus(1'b1, IDX_STATUS, 8'h00);
        n = 0;
        do begin
            bus(1'b0, IDX_STATUS, 8'h00);
            n++;
        end while (rd[7] !== 1'b0 && n < 500);
        rdx(IDX_STATUS, STATUS_ONES);
        bus(1'b1, IDX_CTRL, ZERO_BYTE);
        repeat (2) @(posedge hclk);
        chk({scl_oe, sda_oe}, 2'h0);
        final_report;
    end
endmodule // i2cc_ctrl_bench
bind i2cc_ctrl i2cc_ctrl_asserts i2cc_ctrl_asserts_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata, .scl_o, .scl_oe, .sda_o, .sda_oe, .irq);
